// ---- hdl/port_b_mux_cfg.svh ----
`ifndef PORT_B_MUX_CFG_SVH
`define PORT_B_MUX_CFG_SVH
// Function select codes for decoder pins
`define FSEL_PRIMARY 2'h0
`define FSEL_TIMER 2'h1
`define FSEL_GPIO 2'h2
`define FSEL_CLKOUT 2'h3
// Function select codes for SPI pins
`define SSEL_SPI 2'h0
`define SSEL_GPIO 2'h1
`define SSEL_SERIAL 2'h2
// Pin group sizes the port widths are built for
`define QUAD_PIN_COUNT 4
`define SPI_PIN_COUNT 3
// Reset selects
`define QUAD_SEL_RESET 8'h00
`define SPI_SEL_RESET 6'h00
`endif

// ---- hdl/port_b_mux_pkg.sv ----
package port_b_mux_pkg;
  typedef logic [1:0] quad_sel_t;
  typedef logic [1:0] spi_sel_t;
endpackage

// ---- hdl/pin_driver_select.sv ----
`timescale 1ns/1ps
`include "port_b_mux_cfg.svh"
// One pin's output and enable picked from four candidate sources
module pin_driver_select (
  // Selection
  input wire logic [1:0] sel,
  // Candidates, enable active low
  input wire logic [3:0] cand_out,
  input wire logic [3:0] cand_oe_n,
  // Pin drive
  output logic pin_out,
  output logic pin_oe_n
);
  // Exactly one source owns the driver
  always_comb begin
    pin_out = cand_out[sel];
    pin_oe_n = cand_oe_n[sel];
  end
endmodule // pin_driver_select

// ---- hdl/port_b_pin_function_mux.sv ----
`timescale 1ns/1ps
`include "port_b_mux_cfg.svh"
// Notes on behaviour
// - Reset selects decoder and SPI0 primary functions
// - Each pin switchable to GPIO, own direction
// - Decoder pins alternatively timer A channels 0-3
// - Clock-out select drives monitor clocks onto pins
// - Serial clock output as master, input slave
// - Master-out data set half period early
// - Unselected slave floats master-in output
// - Slave master-in data set half period early
// - Master-in pin selectable as serial1 receive
module port_b_pin_function_mux #(
  // Pin group sizes
  parameter int QUAD_PINS = `QUAD_PIN_COUNT,
  parameter int SPI_PINS = `SPI_PIN_COUNT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Function selects, two bits per pin
  input wire port_b_mux_pkg::quad_sel_t quad_sel_req [4],
  input wire port_b_mux_pkg::spi_sel_t spi_sel_req [3],
  input wire logic sel_load,
  // GPIO for bits 7..1
  input wire logic [7:1] gpio_out,
  input wire logic [7:1] gpio_dir_out,
  output logic [7:1] gpio_in,
  // Timer A channels
  input wire logic [3:0] timer_out,
  input wire logic [3:0] timer_drive,
  output logic [3:0] timer_in,
  // Monitor clocks: oscillator, double, main, prescaler
  input wire logic [3:0] monitor_clk,
  // Decoder inputs
  output logic decoder_phase_a_in,
  output logic decoder_phase_b_in,
  output logic decoder_index_in,
  output logic decoder_home_in,
  // SPI0 core side
  input wire logic spi_master_mode,
  input wire logic spi_slave_selected,
  input wire logic spi_clk_out,
  input wire logic spi_mo_out,
  input wire logic spi_mi_out,
  output logic spi_clk_in,
  output logic spi_mo_in,
  output logic spi_mi_in,
  output logic serial1_receive_in,
  // Pins: decoder pins [3:0] = A,B,index,home; SPI pins [6:4] = clk,mo,mi
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe_n
);
  import port_b_mux_pkg::*;

  // ****************************************
  // Configuration check
  // ****************************************
  // Port widths are fixed, so only the documented pin counts are served
  if (QUAD_PINS != `QUAD_PIN_COUNT || SPI_PINS != `SPI_PIN_COUNT) begin : g_bad_cfg
    $error("pin group sizes not supported");
  end

  // ****************************************
  // Select registers
  // ****************************************
  quad_sel_t quad_sel_reg [4];
  spi_sel_t spi_sel_reg [3];

  // Decoder pin selects, loaded as a block so pins never pass through mixed states
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < QUAD_PINS; i++) begin
      if (rst) begin
        quad_sel_reg[i] <= `FSEL_PRIMARY;
      end else if (sel_load) begin
        quad_sel_reg[i] <= quad_sel_req[i];
      end
    end
  end

  // SPI pin selects, taken by the same strobe
  always_ff @(posedge core_clk) begin
    for (int j = 0; j < SPI_PINS; j++) begin
      if (rst) begin
        spi_sel_reg[j] <= `SSEL_SPI;
      end else if (sel_load) begin
        spi_sel_reg[j] <= spi_sel_req[j];
      end
    end
  end

  // ****************************************
  // Decoder pin drivers
  // ****************************************
  // Bit mapping: pin k of decoder group is port B bit 7-k
  // Controls come in as arguments so the connection follows their changes
  function automatic logic [3:0] cands_oe(input logic dir_out, input logic tmr_drive);
    // Primary inputs never drive; clock out always drives
    cands_oe = {1'b0, ~dir_out, ~tmr_drive, 1'b1};
  endfunction

  genvar g;
  generate
    for (g = 0; g < QUAD_PINS; g++) begin : g_quad
      pin_driver_select u_sel (
        .sel(quad_sel_reg[g]),
        .cand_out({monitor_clk[g], gpio_out[7-g], timer_out[g], 1'b0}),
        .cand_oe_n(cands_oe(gpio_dir_out[7-g], timer_drive[g])),
        .pin_out(pin_out[g]),
        .pin_oe_n(pin_oe_n[g])
      );
      // Input fans out only to the selected function
      assign timer_in[g] = (quad_sel_reg[g] == `FSEL_TIMER) & pin_in[g];
      assign gpio_in[7-g] = (quad_sel_reg[g] == `FSEL_GPIO) & pin_in[g];
    end
  endgenerate

  // Decoder 0 inputs read zero when pin given away
  assign decoder_phase_a_in = (quad_sel_reg[0] == `FSEL_PRIMARY) & pin_in[0];
  assign decoder_phase_b_in = (quad_sel_reg[1] == `FSEL_PRIMARY) & pin_in[1];
  assign decoder_index_in = (quad_sel_reg[2] == `FSEL_PRIMARY) & pin_in[2];
  assign decoder_home_in = (quad_sel_reg[3] == `FSEL_PRIMARY) & pin_in[3];

  // ****************************************
  // SPI pin drivers
  // ****************************************
  // Data timing is the SPI core's job; mux adds no delay so the
  // half-period lead set by the core survives to the pin
  logic spi_mi_drive_n;
  assign spi_mi_drive_n = spi_master_mode | ~spi_slave_selected;

  generate
    for (g = 0; g < SPI_PINS; g++) begin : g_spi
      logic [3:0] c_out;
      logic [3:0] c_oe_n;
      always_comb begin
        c_out = {1'b0, 1'b0, gpio_out[3-g], 1'b0};
        c_oe_n = {1'b1, 1'b1, ~gpio_dir_out[3-g], 1'b1};
        if (g == 0) begin
          c_out[0] = spi_clk_out;
          c_oe_n[0] = ~spi_master_mode;
        end else if (g == 1) begin
          c_out[0] = spi_mo_out;
          c_oe_n[0] = ~spi_master_mode;
        end else begin
          c_out[0] = spi_mi_out;
          c_oe_n[0] = spi_mi_drive_n;
        end
      end
      pin_driver_select u_sel (
        .sel(spi_sel_reg[g]),
        .cand_out(c_out),
        .cand_oe_n(c_oe_n),
        .pin_out(pin_out[4+g]),
        .pin_oe_n(pin_oe_n[4+g])
      );
      assign gpio_in[3-g] = (spi_sel_reg[g] == `SSEL_GPIO) & pin_in[4+g];
    end
  endgenerate

  // SPI inputs; serial receive only on the master-in pin
  assign spi_clk_in = (spi_sel_reg[0] == `SSEL_SPI) & pin_in[4];
  assign spi_mo_in = (spi_sel_reg[1] == `SSEL_SPI) & pin_in[5];
  assign spi_mi_in = (spi_sel_reg[2] == `SSEL_SPI) & pin_in[6];
  assign serial1_receive_in = (spi_sel_reg[2] == `SSEL_SERIAL) & pin_in[6];

  // ****************************************
  // Checks
  // ****************************************
  a_reset_primary: assert property (@(posedge core_clk) rst |=>
    quad_sel_reg[0] == `FSEL_PRIMARY && quad_sel_reg[1] == `FSEL_PRIMARY &&
    quad_sel_reg[2] == `FSEL_PRIMARY && quad_sel_reg[3] == `FSEL_PRIMARY &&
    spi_sel_reg[0] == `SSEL_SPI && spi_sel_reg[1] == `SSEL_SPI && spi_sel_reg[2] == `SSEL_SPI)
    else $error("pin not primary after reset");
  a_slave_mi_float: assert property (@(posedge core_clk) disable iff (rst)
    (spi_sel_reg[2] == `SSEL_SPI && !spi_slave_selected) |-> pin_oe_n[6])
    else $error("master-in driven while unselected");
  a_sclk_master_out: assert property (@(posedge core_clk) disable iff (rst)
    (spi_sel_reg[0] == `SSEL_SPI) |-> (pin_oe_n[4] == !spi_master_mode))
    else $error("serial clock direction wrong");
  a_timer_route: assert property (@(posedge core_clk) disable iff (rst)
    (quad_sel_reg[1] == `FSEL_TIMER) |-> timer_in[1] == pin_in[1])
    else $error("timer input not routed");
  a_clkout_drive: assert property (@(posedge core_clk) disable iff (rst)
    (quad_sel_reg[2] == `FSEL_CLKOUT) |-> !pin_oe_n[2] && pin_out[2] == monitor_clk[2])
    else $error("clock out not driven");
  a_gpio_dir: assert property (@(posedge core_clk) disable iff (rst)
    (spi_sel_reg[1] == `SSEL_GPIO) |-> pin_oe_n[5] == !gpio_dir_out[2])
    else $error("gpio direction wrong");
  a_serial_rx: assert property (@(posedge core_clk) disable iff (rst)
    (spi_sel_reg[2] == `SSEL_SERIAL) |-> serial1_receive_in == pin_in[6] && pin_oe_n[6])
    else $error("serial receive not routed");
  a_decoder_excl: assert property (@(posedge core_clk) disable iff (rst)
    (quad_sel_reg[0] != `FSEL_PRIMARY) |-> !decoder_phase_a_in)
    else $error("decoder sees pin given away");
  a_mo_drive: assert property (@(posedge core_clk) disable iff (rst)
    (spi_sel_reg[1] == `SSEL_SPI && spi_master_mode) |-> pin_out[5] == spi_mo_out)
    else $error("master-out not passed");
  a_mi_drive: assert property (@(posedge core_clk) disable iff (rst)
    (spi_sel_reg[2] == `SSEL_SPI && !spi_mi_drive_n) |-> pin_out[6] == spi_mi_out)
    else $error("master-in not passed");

  // Select load in one step: the edge that takes the strobe applies the selects, seen from the next edge
  sequence s_load_taken;
    sel_load && !rst;
  endsequence
  sequence s_quad0_applied;
    quad_sel_reg[0] == $past(quad_sel_req[0]);
  endsequence
  sequence s_spi2_applied;
    spi_sel_reg[2] == $past(spi_sel_req[2]);
  endsequence
  a_quad_sel_take: assert property (@(posedge core_clk) disable iff (rst)
    s_load_taken |=> s_quad0_applied)
    else $error("decoder pin select not loaded");
  a_spi_sel_take: assert property (@(posedge core_clk) disable iff (rst)
    s_load_taken |=> s_spi2_applied)
    else $error("spi pin select not loaded");

  // Per-function ownership of the pad driver and the serial receive input
  a_gpio_quad_out: assert property (@(posedge core_clk) disable iff (rst)
    (quad_sel_reg[0] == `FSEL_GPIO) |->
    pin_oe_n[0] == !gpio_dir_out[7] && pin_out[0] == gpio_out[7])
    else $error("gpio not driven on decoder pin");
  a_timer_drive: assert property (@(posedge core_clk) disable iff (rst)
    (quad_sel_reg[3] == `FSEL_TIMER) |->
    pin_oe_n[3] == !timer_drive[3] && pin_out[3] == timer_out[3])
    else $error("timer channel not driven");
  a_primary_float: assert property (@(posedge core_clk) disable iff (rst)
    (quad_sel_reg[1] == `FSEL_PRIMARY) |-> pin_oe_n[1])
    else $error("decoder input pin driven");
  a_mi_master_float: assert property (@(posedge core_clk) disable iff (rst)
    (spi_sel_reg[2] == `SSEL_SPI && spi_master_mode) |-> pin_oe_n[6])
    else $error("master-in driven by master");
  a_rx_excl: assert property (@(posedge core_clk) disable iff (rst)
    (spi_sel_reg[2] != `SSEL_SERIAL) |-> !serial1_receive_in)
    else $error("serial receive sees pin given away");
endmodule // port_b_pin_function_mux

// ---- sim/pin_peer_model.sv ----
`timescale 1ns/1ps
// Far side of the pads: encoder or SPI peer
module pin_peer_model (
  // Clock
  input wire logic core_clk,
  // Device and peer drive
  input wire logic [6:0] dev_out,
  input wire logic [6:0] dev_oe_n,
  input wire logic [6:0] peer_val,
  input wire logic [6:0] peer_en,
  // Resolved pads
  output logic [6:0] pad
);
  logic float_reg = 1'b0;
  // Floating pads toggle so a stale level never passes
  always_ff @(posedge core_clk) begin
    float_reg <= ~float_reg;
  end
  // Device wins when driving, peer only when enabled
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pad[i] = !dev_oe_n[i] ? dev_out[i] : peer_en[i] ? peer_val[i] : float_reg;
    end
  end
endmodule // pin_peer_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import port_b_mux_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sel_load = 1'b0;
  quad_sel_t qs [4];
  spi_sel_t ss [3];
  logic [7:1] go = 7'h00, gd = 7'h00, gi;
  logic [3:0] to = 4'h0, td = 4'h0, ti, mc = 4'h0;
  logic da, db, dx, dh, sm = 1'b1, sl = 1'b0, sco = 1'b0, smo = 1'b1, smi = 1'b0;
  logic sci, smoi, smii, rx;
  logic [6:0] pad, po, poe, pv = 7'h6a;
  int failures = 0;
  int checks = 0;
  always #10 core_clk = ~core_clk;
  pin_peer_model peer (.core_clk(core_clk), .dev_out(po), .dev_oe_n(poe), .peer_val(pv),
    .peer_en(7'h7f), .pad(pad));
  port_b_pin_function_mux dut (.core_clk(core_clk), .rst(rst), .quad_sel_req(qs),
    .spi_sel_req(ss), .sel_load(sel_load), .gpio_out(go), .gpio_dir_out(gd), .gpio_in(gi),
    .timer_out(to), .timer_drive(td), .timer_in(ti), .monitor_clk(mc),
    .decoder_phase_a_in(da), .decoder_phase_b_in(db), .decoder_index_in(dx),
    .decoder_home_in(dh), .spi_master_mode(sm), .spi_slave_selected(sl),
    .spi_clk_out(sco), .spi_mo_out(smo), .spi_mi_out(smi), .spi_clk_in(sci),
    .spi_mo_in(smoi), .spi_mi_in(smii), .serial1_receive_in(rx), .pin_in(pad),
    .pin_out(po), .pin_oe_n(poe));
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string n, input logic [6:0] e, input logic [6:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One select on all decoder pins, one on all SPI pins; ends on a falling edge
  task automatic load(input logic [1:0] q, input logic [1:0] s);
    @(negedge core_clk);
    foreach (qs[i]) qs[i] = q;
    foreach (ss[i]) ss[i] = s;
    sel_load = 1'b1;
    @(negedge core_clk);
    sel_load = 1'b0;
  endtask
  function automatic logic [6:0] rev(input logic [6:0] v);
    return {<<{v}};
  endfunction
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    chk("reset oe_n", 7'h4f, poe);
    chk("decoder in", 7'h0a, {3'h0, dh, dx, db, da});
    chk("master drive", 7'h02, {5'h0, po[5:4]});
    chk("mi in", 7'h01, {6'h0, smii});
  endtask
  task automatic t_gpio();
    logic [6:0] d;
    go = 7'h55;
    gd = 7'h0f;
    load(2'h2, 2'h1);
    d = rev(gd);
    chk("gpio oe_n", ~d, poe);
    chk("gpio out", rev(go) & d, po & d);
    chk("gpio in", rev((rev(go) & d) | (pv & ~d)), gi);
    chk("others off", 7'h0, {dh, dx, db, da, sci, smoi, smii});
  endtask
  task automatic t_timer();
    td = 4'h5;
    to = 4'h1;
    load(2'h1, 2'h0);
    chk("timer oe_n", 7'h4a, poe);
    chk("timer out", 7'h01, {3'h0, po[3:0] & td});
    chk("timer in", 7'h0b, {3'h0, ti});
  endtask
  task automatic t_clkout();
    mc = 4'h5;
    load(2'h3, 2'h0);
    chk("clk oe_n", 7'h40, poe);
    mc = 4'ha;
    #1 chk("clk out", 7'h0a, {3'h0, po[3:0]});
  endtask
  task automatic t_slave();
    sm = 1'b0;
    smi = 1'b1;
    pv = 7'h15;
    load(2'h0, 2'h0);
    chk("slave oe_n", 7'h7f, poe);
    chk("slave in", 7'h01, {5'h0, smoi, sci});
    sl = 1'b1;
    #1 chk("slave out", 7'h7f, {poe[5:0], po[6]});
  endtask
  // Peer as master clocks four bits; data lead the rising serial clock by a core cycle
  task automatic t_spi_xfer();
    logic [3:0] pat;
    pat = 4'h9;
    for (int b = 3; b >= 0; b--) begin
      @(negedge core_clk);
      pv[4] = 1'b0;
      pv[5] = pat[b];
      smi = ~pat[b];
      @(negedge core_clk);
      pv[4] = 1'b1;
      #1 chk("xfer mo", {6'h0, pat[b]}, {6'h0, smoi});
      chk("xfer mi", {6'h0, ~pat[b]}, {6'h0, pad[6]});
      chk("xfer clk", 7'h01, {6'h0, sci});
    end
  endtask
  task automatic t_serial();
    load(2'h0, 2'h2);
    pv = 7'h40;
    #1 chk("serial oe_n", 7'h7f, poe);
    chk("serial rx", 7'h01, {4'h0, sci, smoi, rx});
  endtask
  // Watchdog well beyond the few dozen cycles needed
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
  initial begin
    foreach (qs[i]) qs[i] = 2'h0;
    foreach (ss[i]) ss[i] = 2'h0;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_gpio();
    t_timer();
    t_clkout();
    t_slave();
    t_spi_xfer();
    t_serial();
    wrap_up();
  end
endmodule // tb_top
